// >>> logic/tcz_pkg.sv
// constants shared by the timer/counter zero/one block
package tcz_pkg;
  // ****************************************
  // special-function addresses, reset values and unmapped read data
  // ****************************************
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ****************************************
  // mode register fields
  // ****************************************
  localparam int T1_GATE_BIT = 7;
  localparam int T1_SEL_BIT = 6;
  localparam int T1_MODE_LSB = 4;
  localparam int T0_GATE_BIT = 3;
  localparam int T0_SEL_BIT = 2;
  localparam int T0_MODE_LSB = 0;
  // ****************************************
  // machine cycle timing in core clocks, count limits and mode codes
  // ****************************************
  localparam int MC_CLKS = 12;
  localparam int PHASE_W = 4;
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
  localparam logic [3:0] UPDATE_PHASE = 4'h4;
  localparam logic [4:0] PRESCALE_TOP = 5'h1F;
  localparam logic [7:0] BYTE_TOP = 8'hFF;
  typedef enum logic [1:0] {
    MODE_PRESCALE13 = 2'b00,
    MODE_CASCADE16 = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } tcz_mode_t;
endpackage

// >>> logic/tcz_edge_sampler.sv
// count-pin sampler: falling-edge detection once per machine cycle
`timescale 1ns/10ps
`default_nettype none
module tcz_edge_sampler (
  input wire logic i_clk,    // core clock
  input wire logic i_rst_n,  // async reset, active low
  input wire logic i_sample, // sample-phase strobe
  input wire logic i_update, // update-phase strobe
  input wire logic i_pin,    // external count pin
  input wire logic i_ext,    // 1: count pin, 0: machine cycles
  input wire logic i_en,     // run and gate condition
  output logic o_inc         // increment now
);
  logic cur_reg;
  logic fall_reg;
  wire fall_next = cur_reg & ~i_pin;
  // sample once per machine cycle; a fall needs high then low samples
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else if (i_sample) begin
      cur_reg <= i_pin;
      fall_reg <= fall_next;
    end
  end
  // the detected fall shows at the next update phase, so two cycles per count
  assign o_inc = i_update & i_en & (i_ext ? fall_reg : 1'b1);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  fall_seen_a: assert property ((i_sample && cur_reg && !i_pin) |=> fall_reg)
    else $error("falling sample pair not recorded");
  no_rise_a: assert property ((i_sample && !(cur_reg && !i_pin)) |=> !fall_reg)
    else $error("count recorded without a falling edge");
  ext_rate_a: assert property ((o_inc && i_ext) |=> !o_inc [*8])
    else $error("external counts too close together");
  ext_count_c: cover property (o_inc && i_ext);
endmodule
`default_nettype wire

// >>> logic/tcz_timer_pair.sv
// timer/counter zero and one: mode register, count bytes, counting logic
`timescale 1ns/10ps
`default_nettype none
module tcz_timer_pair #(
  parameter int CYC_LEN = tcz_pkg::MC_CLKS // core clocks per machine cycle
) (
  input wire logic i_clk,                // core clock, 25 MHz
  input wire logic i_rst_n,              // async reset, active low
  input wire logic [7:0] i_sfr_addr,     // special-function address
  input wire logic i_sfr_we,             // byte write strobe
  input wire logic [7:0] i_sfr_wdata,    // write data
  input wire logic i_sfr_re,             // read strobe
  input wire logic i_timer_zero_run_bit, // timer zero run
  input wire logic i_timer_one_run_bit,  // timer one run
  input wire logic i_gate_pin_zero,      // external gate for timer zero
  input wire logic i_gate_pin_one,       // external gate for timer one
  input wire logic i_count_pin_zero,     // external count input zero
  input wire logic i_count_pin_one,      // external count input one
  output logic [7:0] o_sfr_rdata,        // read data, one cycle after strobe
  output logic o_ovf_zero,               // timer zero overflow pulse
  output logic o_ovf_one                 // timer one (or split high byte) overflow pulse
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (CYC_LEN < 2 || CYC_LEN > 16 || CYC_LEN <= int'(tcz_pkg::SAMPLE_PHASE)) begin : g_bad_len
    $error("machine cycle length not supported");
  end

  // ****************************************
  // machine cycle phase divider
  // ****************************************
  localparam logic [3:0] LAST_PHASE = 4'(CYC_LEN - 1);
  logic [tcz_pkg::PHASE_W-1:0] phase_reg;
  wire sample_en = (phase_reg == tcz_pkg::SAMPLE_PHASE);
  wire update_en = (phase_reg == tcz_pkg::UPDATE_PHASE);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg <= 4'h0;
    end else if (phase_reg == LAST_PHASE) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  // ****************************************
  // registers and decode
  // ****************************************
  logic [7:0] mode_reg;
  logic [7:0] tl0_reg;
  logic [7:0] th0_reg;
  logic [7:0] tl1_reg;
  logic [7:0] th1_reg;

  function automatic logic wr_at(input logic we, input logic [7:0] a, input logic [7:0] t);
    wr_at = we && (a == t);
  endfunction

  wire wr_mode = wr_at(i_sfr_we, i_sfr_addr, tcz_pkg::ADDR_MODE);
  wire wr_tl0 = wr_at(i_sfr_we, i_sfr_addr, tcz_pkg::ADDR_T0_LOW);
  wire wr_th0 = wr_at(i_sfr_we, i_sfr_addr, tcz_pkg::ADDR_T0_HIGH);
  wire wr_tl1 = wr_at(i_sfr_we, i_sfr_addr, tcz_pkg::ADDR_T1_LOW);
  wire wr_th1 = wr_at(i_sfr_we, i_sfr_addr, tcz_pkg::ADDR_T1_HIGH);

  // each nibble has the same layout; timer zero uses the low one
  wire gate0 = mode_reg[tcz_pkg::T0_GATE_BIT];
  wire sel0 = mode_reg[tcz_pkg::T0_SEL_BIT];
  wire [1:0] mode0 = mode_reg[tcz_pkg::T0_MODE_LSB +: 2];
  wire gate1 = mode_reg[tcz_pkg::T1_GATE_BIT];
  wire sel1 = mode_reg[tcz_pkg::T1_SEL_BIT];
  wire [1:0] mode1 = mode_reg[tcz_pkg::T1_MODE_LSB +: 2];

  wire en0 = i_timer_zero_run_bit & (~gate0 | i_gate_pin_zero);
  wire en1 = i_timer_one_run_bit & (~gate1 | i_gate_pin_one);

  // ****************************************
  // count sources
  // ****************************************
  logic [1:0] inc;
  wire [1:0] pins = {i_count_pin_one, i_count_pin_zero};
  wire [1:0] sels = {sel1, sel0};
  wire [1:0] ens = {en1, en0};
  for (genvar g = 0; g < 2; g++) begin : g_src
    tcz_edge_sampler u_src (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_sample(sample_en),
      .i_update(update_en),
      .i_pin(pins[g]),
      .i_ext(sels[g]),
      .i_en(ens[g]),
      .o_inc(inc[g])
    );
  end

  // ****************************************
  // counting step per mode
  // ****************************************
  // returns {overflow, high, low}; the split mode is handled by the caller
  function automatic logic [16:0] tcz_step(input logic [1:0] m, input logic [7:0] th,
                                          input logic [7:0] tl);
    logic roll;
    logic [4:0] lo5;
    roll = (tl[4:0] == tcz_pkg::PRESCALE_TOP);
    lo5 = tl[4:0] + 5'h01;
    unique case (tcz_pkg::tcz_mode_t'(m))
      tcz_pkg::MODE_PRESCALE13: begin
        // upper three low-byte bits are left alone in this mode
        tcz_step = {roll & (th == tcz_pkg::BYTE_TOP),
                    roll ? th + 8'h01 : th, tl[7:5], lo5};
      end
      tcz_pkg::MODE_CASCADE16: begin
        tcz_step = {1'b0, th, tl} + 17'h00001;
      end
      tcz_pkg::MODE_RELOAD8: begin
        tcz_step = (tl == tcz_pkg::BYTE_TOP) ? {1'b1, th, th} : {1'b0, th, tl + 8'h01};
      end
      tcz_pkg::MODE_SPLIT: begin
        tcz_step = {1'b0, th, tl};
      end
    endcase
  endfunction

  wire split0 = (mode0 == 2'b11);
  wire [16:0] step0 = tcz_step(mode0, th0_reg, tl0_reg);
  wire [16:0] step1 = tcz_step(mode1, th1_reg, tl1_reg);
  wire [8:0] split_lo = {1'b0, tl0_reg} + 9'h001;
  wire [8:0] split_hi = {1'b0, th0_reg} + 9'h001;
  wire split_hi_inc = split0 & update_en & i_timer_one_run_bit;

  wire [7:0] tl0_next = wr_tl0 ? i_sfr_wdata :
                        !inc[0] ? tl0_reg :
                        split0 ? split_lo[7:0] : step0[7:0];
  wire [7:0] th0_next = wr_th0 ? i_sfr_wdata :
                        split0 ? (split_hi_inc ? split_hi[7:0] : th0_reg) :
                        inc[0] ? step0[15:8] : th0_reg;
  wire [7:0] tl1_next = wr_tl1 ? i_sfr_wdata : inc[1] ? step1[7:0] : tl1_reg;
  wire [7:0] th1_next = wr_th1 ? i_sfr_wdata : inc[1] ? step1[15:8] : th1_reg;
  wire ovf0_next = inc[0] & (split0 ? split_lo[8] : step0[16]);
  wire ovf1_next = (inc[1] & step1[16]) | (split_hi_inc & split_hi[8]);

  // ****************************************
  // read path
  // ****************************************
  wire [7:0] rd_sel = (i_sfr_addr == tcz_pkg::ADDR_MODE) ? mode_reg :
                      (i_sfr_addr == tcz_pkg::ADDR_T0_LOW) ? tl0_reg :
                      (i_sfr_addr == tcz_pkg::ADDR_T0_HIGH) ? th0_reg :
                      (i_sfr_addr == tcz_pkg::ADDR_T1_LOW) ? tl1_reg :
                      (i_sfr_addr == tcz_pkg::ADDR_T1_HIGH) ? th1_reg :
                      tcz_pkg::UNMAPPED_READ;

  // software writes win over a count in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= tcz_pkg::MODE_RESET;
      tl0_reg <= tcz_pkg::COUNT_RESET;
      th0_reg <= tcz_pkg::COUNT_RESET;
      tl1_reg <= tcz_pkg::COUNT_RESET;
      th1_reg <= tcz_pkg::COUNT_RESET;
      o_sfr_rdata <= tcz_pkg::UNMAPPED_READ;
      o_ovf_zero <= 1'b0;
      o_ovf_one <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= i_sfr_wdata;
      end
      if (i_sfr_re) begin
        o_sfr_rdata <= rd_sel;
      end
      tl0_reg <= tl0_next;
      th0_reg <= th0_next;
      tl1_reg <= tl1_next;
      th1_reg <= th1_next;
      o_ovf_zero <= ovf0_next;
      o_ovf_one <= ovf1_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  inc_phase_a: assert property ((|inc) |-> phase_reg == tcz_pkg::UPDATE_PHASE)
    else $error("count outside the update phase");
  timer_rate_a: assert property ((inc[0] && !sel0) |=> !inc[0] [*8] ##3 !inc[0])
    else $error("timer counts faster than once per machine cycle");
  gate_one_a: assert property (inc[1] |-> i_timer_one_run_bit && (!gate1 || i_gate_pin_one))
    else $error("timer one counted while gated off");
  prescale_a: assert property ((inc[0] && mode0 == 2'b00 && !wr_th0 && !wr_tl0
                                && tl0_reg[4:0] == 5'h1F)
                               |=> th0_reg == $past(th0_reg) + 8'h01 && tl0_reg[4:0] == 5'h00)
    else $error("prescaler rollover did not bump high byte");
  cascade_a: assert property ((inc[1] && mode1 == 2'b01 && !wr_th1 && !wr_tl1)
                              |=> {th1_reg, tl1_reg} == $past({th1_reg, tl1_reg}) + 16'h0001)
    else $error("16-bit count step wrong");
  reload_a: assert property ((inc[1] && mode1 == 2'b10 && !wr_th1 && !wr_tl1
                              && tl1_reg == 8'hFF) |=> tl1_reg == $past(th1_reg) && o_ovf_one)
    else $error("reload from high byte missing");
  halt_a: assert property ((mode1 == 2'b11 && !wr_th1 && !wr_tl1)
                           |=> $stable(tl1_reg) && $stable(th1_reg))
    else $error("timer one counted while halted");
  split_a: assert property ((split0 && update_en && i_timer_one_run_bit && !wr_th0)
                            |=> th0_reg == $past(th0_reg) + 8'h01)
    else $error("split high byte did not count");
  mode_wr_a: assert property (wr_mode |=> mode_reg == $past(i_sfr_wdata))
    else $error("mode register write lost");
  ovf_zero_c: cover property (o_ovf_zero);
  split_c: cover property (split0 && split_hi_inc);
  reload_c: cover property (mode1 == 2'b10 && o_ovf_one);
endmodule
`default_nettype wire

// >>> test/tcz_pin_model.sv
// behavioural outside party: source of falling edges on the count pins
`timescale 1ns/10ps
`default_nettype none
module tcz_pin_model (
  input wire logic i_clk,        // core clock
  input wire logic i_go,         // start a burst of falling edges
  input wire logic [7:0] i_n,    // falling edges in the burst
  input wire logic [4:0] i_hold, // clocks per level, 12 or more
  output logic o_pin,            // count pin, idles high
  output logic o_done            // burst finished
);
  // ****************************************
  // edge burst
  // ****************************************
  initial begin
    o_pin = 1'b1;
    o_done = 1'b1;
    forever begin
      @(posedge i_go);
      o_done = 1'b0;
      repeat (i_n) begin
        @(negedge i_clk);
        o_pin = 1'b0;
        // each level spans a full machine cycle so none goes unsampled
        repeat (i_hold) @(negedge i_clk);
        o_pin = 1'b1;
        repeat (i_hold - 5'h01) @(negedge i_clk);
      end
      @(negedge i_clk);
      o_done = 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the timer/counter zero/one pair
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [1:0] run = 2'b00;
  logic gate = 1'b0;
  logic go = 1'b0;
  logic [7:0] n_edges = 8'h00;
  logic [4:0] hold = 5'h0C;
  logic [7:0] rdata;
  wire logic pin;
  wire logic done;
  wire logic ovf0;
  wire logic ovf1;
  int n_ovf0 = 0;
  int n_ovf1 = 0;
  int n_errors = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  tcz_timer_pair #(.CYC_LEN(12)) u_tcz_timer_pair (
    .i_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_we(we),
    .i_sfr_wdata(wdata), .i_sfr_re(re), .i_timer_zero_run_bit(run[0]),
    .i_timer_one_run_bit(run[1]), .i_gate_pin_zero(gate), .i_gate_pin_one(gate),
    .i_count_pin_zero(pin), .i_count_pin_one(pin), .o_sfr_rdata(rdata),
    .o_ovf_zero(ovf0), .o_ovf_one(ovf1));
  // overflow outputs are one-cycle pulses, so every rising clock edge is looked at
  always @(posedge clk) begin
    if (ovf0 === 1'b1) n_ovf0++;
    if (ovf1 === 1'b1) n_ovf1++;
  end
  tcz_pin_model u_tcz_pin_model (.i_clk(clk), .i_go(go), .i_n(n_edges),
    .i_hold(hold), .o_pin(pin), .o_done(done));
  // ****************************************
  // expectation model and bus tasks
  // ****************************************
  function automatic logic [15:0] step(input logic [1:0] m, input logic [15:0] v);
    case (m)
      2'b00: step = (v[4:0] == 5'h1F) ? {v[15:8] + 8'h01, v[7:5], 5'h00} : v + 16'h0001;
      2'b01: step = v + 16'h0001;
      2'b10: step = (v[7:0] == 8'hFF) ? {v[15:8], v[15:8]} : v + 16'h0001;
      default: step = v;
    endcase
  endfunction
  function automatic logic ovf_of(input logic [1:0] m, input logic [15:0] v);
    case (m)
      2'b00: ovf_of = (v[4:0] == 5'h1F) && (v[15:8] == 8'hFF);
      2'b01: ovf_of = (v == 16'hFFFF);
      2'b10: ovf_of = (v[7:0] == 8'hFF);
      default: ovf_of = 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] byte_addr(input int t, input bit hi);
    if (hi) return (t != 0) ? tcz_pkg::ADDR_T1_HIGH : tcz_pkg::ADDR_T0_HIGH;
    return (t != 0) ? tcz_pkg::ADDR_T1_LOW : tcz_pkg::ADDR_T0_LOW;
  endfunction
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    @(negedge clk);
    check(what, rdata, exp);
  endtask
  // loads one timer, lets it run n machine cycles or n pin falls, then reads it back
  task automatic run_one(input int t, input logic [3:0] md, input logic [7:0] lo,
                         input logic [7:0] hi, input int n, input logic g);
    logic [15:0] v;
    int k;
    int base;
    int n_ov;
    n_ov = 0;
    k = (md[3] && !g) ? 0 : n;
    v = {hi, lo};
    gate = g;
    wr(tcz_pkg::ADDR_MODE, (t != 0) ? {md, 4'h0} : {4'h0, md});
    wr(byte_addr(t, 1'b0), lo);
    wr(byte_addr(t, 1'b1), hi);
    @(negedge clk);
    base = (t != 0) ? n_ovf1 : n_ovf0;
    run[t] = 1'b1;
    if (md[2]) begin
      n_edges = 8'(n);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      for (int w = 0; w < 5000 && done !== 1'b1; w++) @(negedge clk);
      repeat (48) @(negedge clk);
    end else begin
      repeat (12 * n) @(negedge clk);
    end
    run[t] = 1'b0;
    for (int i = 0; i < k; i++) begin
      n_ov += int'(ovf_of(md[1:0], v));
      v = step(md[1:0], v);
    end
    repeat (2) @(negedge clk);
    check("overflow pulses", 8'(((t != 0) ? n_ovf1 : n_ovf0) - base), 8'(n_ov));
    rd(byte_addr(t, 1'b0), v[7:0], "low byte");
    rd(byte_addr(t, 1'b1), v[15:8], "high byte");
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h93BA));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(tcz_pkg::ADDR_MODE, tcz_pkg::MODE_RESET, "mode reset");
    for (int a = 8'h8A; a <= 8'h8D; a++) rd(8'(a), tcz_pkg::COUNT_RESET, "count reset");
    rd(8'h88, tcz_pkg::UNMAPPED_READ, "unmapped read");
    wr(tcz_pkg::ADDR_MODE, 8'hA5);
    wr(8'h88, 8'h5A);
    rd(tcz_pkg::ADDR_MODE, 8'hA5, "mode byte");
    run_one(0, 4'h0, 8'hBE, 8'h7F, 3, 1'b0);
    run_one(1, 4'h1, 8'hFF, 8'hFF, 2, 1'b0);
    run_one(0, 4'h2, 8'hFE, 8'h40, 4, 1'b0);
    run_one(1, 4'h3, 8'h12, 8'h34, 5, 1'b0);
    run_one(1, 4'h9, 8'h00, 8'h00, 4, 1'b0);
    run_one(0, 4'h9, 8'h10, 8'h00, 4, 1'b1);
    run_one(1, 4'h5, 8'hFD, 8'h00, 6, 1'b0);
    wr(tcz_pkg::ADDR_MODE, 8'h03);
    wr(tcz_pkg::ADDR_T0_LOW, 8'h77);
    wr(tcz_pkg::ADDR_T0_HIGH, 8'hFE);
    run = 2'b10;
    repeat (60) @(negedge clk);
    run = 2'b01;
    repeat (36) @(negedge clk);
    run = 2'b00;
    rd(tcz_pkg::ADDR_T0_HIGH, 8'h03, "split high");
    rd(tcz_pkg::ADDR_T0_LOW, 8'h7A, "split low");
    repeat (14) begin
      hold = 5'(12 + $urandom_range(0, 4));
      run_one(int'($urandom_range(0, 1)), {1'($urandom), 1'($urandom),
              2'($urandom_range(0, 2))}, 8'($urandom), 8'($urandom),
              int'($urandom_range(1, 20)), 1'($urandom));
    end
    stop_test;
  end
endmodule
`default_nettype wire
